// ==== hdl/t1p_timer.sv ====
// 16-bit prescaled up timer with capture unit behind an APB slave
//
// Overview of operation
// - Counter halts while timer enable is 0, counts while it is 1 unless enabled capture gates it to the measurement window.
// - Counter steps by one on each prescaled timer clock.
// - Wrap from full scale to zero sets the overflow request flag.
// - Overflow flag stays set until software clears it.
// - No automatic reload; software rewrites both bytes after overflow.
// - With interrupt enabled, an overflow requests vector 000FH.
// - Clock source bit: 0 instruction clock, 1 high-speed oscillator.
// - Rate 000 divides by 128, each step halves, 111 divides by 1.
// - 65536 steps, each one prescaled clock period long.
// - Timer and capture keep running in green mode without wake-up.
// - Timer works in normal, slow and green power modes.
// - Flag also sets when the capture measurement stops.
// - Capture measures high, low, cycle and duration on the input pin.
// - Resolution follows timer clock; start and stop edges are fixed by the capture select.
// - Separate 16-bit event counter counts input events upward.
// - High byte write is held; low byte write loads all 16 bits.
// - Low byte read latches the high byte for the following read.
// - Capture select: 00 duration, 01 high, 10 low, 11 cycle.
// - Capture works only with capture enable and timer enable set.
//
// Design decision made here: register access over APB.
`include "t1p_defs.svh"

module t1p_timer (
   // Clock and reset
   input  wire logic                 core_clk,
   input  wire logic                 nrst,
   // APB slave
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [`T1P_AW-1:0]   paddr,
   input  wire logic [31:0]          pwdata,
   output logic      [31:0]          prdata,
   output logic                      pready,
   output logic                      pslverr,
   // Clock source ticks, one core_clk cycle each
   input  wire logic                 fcpu_tick,
   input  wire logic                 fhosc_tick,
   // System
   input  wire t1p_pkg::t1p_pwr_t    power_mode,
   input  wire logic                 capture_input_pin,
   output t1p_pkg::t1p_vec_t         vector_request,
   output logic                      wake_request
);

   // Registers
   t1p_pkg::t1p_mode_t mode_control_register_r;
   t1p_pkg::t1p_mode_t mode_nxt;
   t1p_pkg::t1p_cpt_t  cpt_r;
   t1p_pkg::t1p_cpt_t  cpt_nxt;
   t1p_pkg::t1p_cst_t  cst_r;
   t1p_pkg::t1p_cst_t  cst_nxt;
   logic               overflow_request_flag_r;
   logic               flag_nxt;
   logic               overflow_interrupt_enable_r;
   logic               ien_nxt;
   logic               vec_req_r;
   logic               vec_req_nxt;
   logic [7:0]         cnt_hi_buf_r;
   logic [7:0]         cnt_hi_buf_nxt;
   logic [7:0]         cnt_rd_hi_r;
   logic [7:0]         cnt_rd_hi_nxt;
   logic [7:0]         evt_hi_buf_r;
   logic [7:0]         evt_hi_buf_nxt;
   logic [7:0]         evt_rd_hi_r;
   logic [7:0]         evt_rd_hi_nxt;
   logic               pin_d_r;

   // Counters
   logic [15:0]        tmr_count;
   logic               tmr_wrap;
   logic [15:0]        evt_count;
   logic               evt_wrap;
   logic               pre_step;

   // Bus decode
   wire                access;
   wire                wr;
   wire                rd;
   wire                word_ok;
   wire  [7:0]         idx;
   wire  [7:0]         wbyte;
   wire                hit_mode;
   wire                hit_lo;
   wire                hit_hi;
   wire                hit_cpt;
   wire                hit_stat;
   wire                hit_elo;
   wire                hit_ehi;
   wire                hit;
   wire  [7:0]         rbyte;
   wire  [7:0]         stat_byte;

   assign access   = psel & penable;
   assign wr       = access & pwrite;
   assign rd       = access & ~pwrite;
   assign word_ok  = (paddr[1:0] == 2'b00) &
                     (paddr[`T1P_AW-1:`T1P_IDX_MSB+1] == 2'b00);
   assign idx      = paddr[`T1P_IDX_MSB:`T1P_IDX_LSB];
   assign wbyte    = pwdata[7:0];
   assign hit_mode = word_ok & (idx == `T1P_IDX_MODE);
   assign hit_lo   = word_ok & (idx == `T1P_IDX_CNT_LO);
   assign hit_hi   = word_ok & (idx == `T1P_IDX_CNT_HI);
   assign hit_cpt  = word_ok & (idx == `T1P_IDX_CPT);
   assign hit_stat = word_ok & (idx == `T1P_IDX_STAT);
   assign hit_elo  = word_ok & (idx == `T1P_IDX_EVT_LO);
   assign hit_ehi  = word_ok & (idx == `T1P_IDX_EVT_HI);
   assign hit      = hit_mode | hit_lo | hit_hi | hit_cpt | hit_stat |
                     hit_elo | hit_ehi;

   // Zero wait states; unmapped or misaligned words answer with an error
   assign pready   = 1'b1;
   assign pslverr  = access & ~hit;

   assign stat_byte = {6'h00, overflow_interrupt_enable_r,
                       overflow_request_flag_r};

   // High-byte reads return the copy taken at the last low-byte read
   assign rbyte = hit_mode ? mode_control_register_r :
                  hit_lo   ? tmr_count[7:0] :
                  hit_hi   ? cnt_rd_hi_r :
                  hit_cpt  ? cpt_r :
                  hit_stat ? stat_byte :
                  hit_elo  ? evt_count[7:0] :
                  hit_ehi  ? evt_rd_hi_r : `T1P_BYTE_RST;
   assign prdata = {24'h000000, rbyte};

   // Mode register; reserved bits never store
   assign mode_nxt = (wr & hit_mode) ? {wbyte[7:3], 3'b000} :
                     mode_control_register_r;

   // Prescaler: source select and run gating
   wire timer_enable_bit;
   wire clock_source_select;
   wire src_tick;

   assign timer_enable_bit    = mode_control_register_r.enb;
   assign clock_source_select = mode_control_register_r.cks;
   assign src_tick = clock_source_select ? fhosc_tick : fcpu_tick;

   // Power mode does not gate counting: same behaviour in every mode
   t1p_prescale u_prescale (
      .core_clk (core_clk),
      .nrst     (nrst),
      .run      (timer_enable_bit),
      .src_tick (src_tick),
      .rate     (mode_control_register_r.rate),
      .step     (pre_step)
   );

   // Capture input edges; pin is taken as synchronous already
   wire pin_rise;
   wire pin_fall;
   wire cap_on;
   wire start_edge;
   wire stop_cond;
   wire cpt_stop;
   wire cpt_run;

   assign pin_rise = capture_input_pin & ~pin_d_r;
   assign pin_fall = ~capture_input_pin & pin_d_r;
   assign cap_on   = cpt_r.en & timer_enable_bit;
   assign cpt_run  = cst_r == t1p_pkg::ST_RUN;

   // Low pulse starts on a fall, every other function on a rise
   assign start_edge = (cpt_r.sel == t1p_pkg::CPT_LOW) ? pin_fall :
                       pin_rise;
   assign stop_cond  =
      (cpt_r.sel == t1p_pkg::CPT_DUR)  ? (cpt_r.md ? tmr_wrap : evt_wrap) :
      (cpt_r.sel == t1p_pkg::CPT_HIGH) ? pin_fall :
      pin_rise;
   assign cpt_stop   = cpt_run & cap_on & cpt_r.start & stop_cond;

   always_comb begin
      cst_nxt = cst_r;
      case (cst_r)
         t1p_pkg::ST_IDLE: begin
            if (cap_on && cpt_r.start)
               cst_nxt = t1p_pkg::ST_ARM;
         end
         t1p_pkg::ST_ARM: begin
            if (!cap_on || !cpt_r.start)
               cst_nxt = t1p_pkg::ST_IDLE;
            else if (start_edge)
               cst_nxt = t1p_pkg::ST_RUN;
         end
         t1p_pkg::ST_RUN: begin
            if (!cap_on || !cpt_r.start || stop_cond)
               cst_nxt = t1p_pkg::ST_IDLE;
         end
         default: cst_nxt = t1p_pkg::ST_IDLE;
      endcase
   end

   // Capture control; the hardware stop clears start over a software write
   always_comb begin
      cpt_nxt = cpt_r;
      if (wr && hit_cpt)
         cpt_nxt = {wbyte[7], 3'b000, wbyte[3:0]};
      if (cpt_stop)
         cpt_nxt.start = 1'b0;
   end

   // Timer counter: free running unless capture gates it to the window
   wire tmr_inc;
   wire tmr_load;
   wire evt_inc;
   wire evt_load;

   assign tmr_inc  = pre_step & (~cap_on | cpt_run);
   assign tmr_load = wr & hit_lo;
   assign evt_inc  = cpt_run & cap_on & cpt_r.start &
                     (cpt_r.sel == t1p_pkg::CPT_DUR) & pin_rise;
   assign evt_load = wr & hit_elo;

   // Full 16-bit span; a wrap leaves zero, nothing is reloaded
   t1p_cnt16 u_tmr_cnt (
      .core_clk (core_clk),
      .nrst     (nrst),
      .inc      (tmr_inc),
      .load     (tmr_load),
      .load_val ({cnt_hi_buf_r, wbyte}),
      .count    (tmr_count),
      .wrap     (tmr_wrap)
   );

   t1p_cnt16 u_evt_cnt (
      .core_clk (core_clk),
      .nrst     (nrst),
      .inc      (evt_inc),
      .load     (evt_load),
      .load_val ({evt_hi_buf_r, wbyte}),
      .count    (evt_count),
      .wrap     (evt_wrap)
   );

   // Byte pairing buffers for both counters
   assign cnt_hi_buf_nxt = (wr & hit_hi) ? wbyte : cnt_hi_buf_r;
   assign cnt_rd_hi_nxt  = (rd & hit_lo) ? tmr_count[15:8] :
                           cnt_rd_hi_r;
   assign evt_hi_buf_nxt = (wr & hit_ehi) ? wbyte : evt_hi_buf_r;
   assign evt_rd_hi_nxt  = (rd & hit_elo) ? evt_count[15:8] : evt_rd_hi_r;

   // Flag: hardware only sets; a set in the clearing cycle wins
   wire flag_set;

   assign flag_set = tmr_wrap | cpt_stop;
   assign flag_nxt = flag_set | ((wr & hit_stat) ?
                     wbyte[`T1P_STAT_FLAG] :
                     overflow_request_flag_r);
   assign ien_nxt  = (wr & hit_stat) ? wbyte[`T1P_STAT_IEN] :
                     overflow_interrupt_enable_r;
   assign vec_req_nxt = flag_nxt & ien_nxt;

   assign vector_request.req  = vec_req_r;
   assign vector_request.addr = `T1P_VECTOR;
   // Green mode keeps counting but must never pull the system awake
   assign wake_request = vec_req_r &
                         (power_mode != t1p_pkg::PM_GREEN);

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         mode_control_register_r     <= `T1P_MODE_RST;
         cpt_r                       <= `T1P_CPT_RST;
         cst_r                       <= t1p_pkg::ST_IDLE;
         overflow_request_flag_r     <= 1'b0;
         overflow_interrupt_enable_r <= 1'b0;
         vec_req_r                   <= 1'b0;
         cnt_hi_buf_r                <= `T1P_BYTE_RST;
         cnt_rd_hi_r                 <= `T1P_BYTE_RST;
         evt_hi_buf_r                <= `T1P_BYTE_RST;
         evt_rd_hi_r                 <= `T1P_BYTE_RST;
         pin_d_r                     <= 1'b0;
      end else begin
         mode_control_register_r     <= mode_nxt;
         cpt_r                       <= cpt_nxt;
         cst_r                       <= cst_nxt;
         overflow_request_flag_r     <= flag_nxt;
         overflow_interrupt_enable_r <= ien_nxt;
         vec_req_r                   <= vec_req_nxt;
         cnt_hi_buf_r                <= cnt_hi_buf_nxt;
         cnt_rd_hi_r                 <= cnt_rd_hi_nxt;
         evt_hi_buf_r                <= evt_hi_buf_nxt;
         evt_rd_hi_r                 <= evt_rd_hi_nxt;
         pin_d_r                     <= capture_input_pin;
      end
   end

endmodule

// ==== hdl/t1p_defs.svh ====
// Register indices, reset values and constants of the 16-bit prescaled timer
`ifndef T1P_DEFS_SVH
`define T1P_DEFS_SVH

// Register indices; the byte address on the bus is four times the index
`define T1P_IDX_MODE    8'hc0
`define T1P_IDX_CNT_LO  8'hc1
`define T1P_IDX_CNT_HI  8'hc2
`define T1P_IDX_CPT     8'hc3
`define T1P_IDX_STAT    8'hc4
`define T1P_IDX_EVT_LO  8'hc5
`define T1P_IDX_EVT_HI  8'hc6

// Bus address layout
`define T1P_AW          12
`define T1P_IDX_LSB     2
`define T1P_IDX_MSB     9

// Reset values
`define T1P_MODE_RST    8'h00
`define T1P_CPT_RST     8'h00
`define T1P_CNT_RST     16'h0000
`define T1P_BYTE_RST    8'h00

// Status register field positions
`define T1P_STAT_FLAG   0
`define T1P_STAT_IEN    1

// Counting constants and interrupt vector address
`define T1P_PRE_FULL    7'h7f
`define T1P_CNT_FULL    16'hffff
`define T1P_VECTOR      16'h000f

`endif

// ==== hdl/t1p_pkg.sv ====
// Types shared by the 16-bit prescaled timer design files
package t1p_pkg;

   typedef struct packed {
      logic       enb;
      logic [2:0] rate;
      logic       cks;
      logic [2:0] rsvd;
   } t1p_mode_t;

   typedef enum logic [1:0] {
      CPT_DUR   = 2'b00,
      CPT_HIGH  = 2'b01,
      CPT_LOW   = 2'b10,
      CPT_CYCLE = 2'b11
   } t1p_cpt_sel_t;

   typedef struct packed {
      logic         en;
      logic [2:0]   rsvd;
      logic         md;
      logic         start;
      t1p_cpt_sel_t sel;
   } t1p_cpt_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_ARM  = 2'b01,
      ST_RUN  = 2'b10
   } t1p_cst_t;

   typedef enum logic [1:0] {
      PM_NORMAL = 2'b00,
      PM_SLOW   = 2'b01,
      PM_GREEN  = 2'b10
   } t1p_pwr_t;

   typedef struct packed {
      logic        req;
      logic [15:0] addr;
   } t1p_vec_t;

endpackage

// ==== hdl/t1p_prescale.sv ====
// Seven-stage prescaler producing one count step per selected division
`include "t1p_defs.svh"

module t1p_prescale (
   // Clock and reset
   input  wire logic       core_clk,
   input  wire logic       nrst,
   // Control
   input  wire logic       run,
   input  wire logic       src_tick,
   input  wire logic [2:0] rate,
   // Result
   output logic            step
);

   logic [6:0] cnt_r;
   logic [6:0] cnt_nxt;
   wire  [6:0] mask;
   wire        adv;

   // Rate 000 waits for all seven bits (divide by 128), 111 for none
   assign mask    = `T1P_PRE_FULL >> rate;
   assign adv     = run & src_tick;
   assign step    = adv & ((cnt_r & mask) == mask);
   // Held while stopped so a re-enable resumes mid-division
   assign cnt_nxt = adv ? cnt_r + 7'h01 : cnt_r;

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst)
         cnt_r <= 7'h00;
      else
         cnt_r <= cnt_nxt;
   end

endmodule

// ==== hdl/t1p_cnt16.sv ====
// Loadable 16-bit up counter with wrap pulse
`include "t1p_defs.svh"

module t1p_cnt16 (
   // Clock and reset
   input  wire logic        core_clk,
   input  wire logic        nrst,
   // Control
   input  wire logic        inc,
   input  wire logic        load,
   input  wire logic [15:0] load_val,
   // State
   output logic [15:0]      count,
   output logic             wrap
);

   logic [15:0] cnt_nxt;

   // A load in the same cycle overrides the step, so no wrap is flagged
   assign wrap    = inc & ~load & (count == `T1P_CNT_FULL);
   assign cnt_nxt = load ? load_val :
                    inc  ? count + 16'h0001 : count;

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst)
         count <= `T1P_CNT_RST;
      else
         count <= cnt_nxt;
   end

endmodule

// ==== testbench/t1p_timer_sva.sv ====
// Assertion checker for the prescaled timer, bound to its top module
`include "t1p_defs.svh"

module t1p_timer_sva (
   // Clock and reset
   input wire logic               core_clk,
   input wire logic               nrst,
   // APB slave
   input wire logic               psel,
   input wire logic               penable,
   input wire logic               pwrite,
   input wire logic [`T1P_AW-1:0] paddr,
   input wire logic [31:0]        pwdata,
   input wire logic [31:0]        prdata,
   input wire logic               pready,
   input wire logic               pslverr,
   // Sources and system
   input wire logic               fcpu_tick,
   input wire logic               fhosc_tick,
   input wire t1p_pkg::t1p_pwr_t  power_mode,
   input wire logic               capture_input_pin,
   input wire t1p_pkg::t1p_vec_t  vector_request,
   input wire logic               wake_request
);
   timeunit 1ns;
   timeprecision 1ps;
   logic       wr;
   logic       stat_wr;
   logic       quiet;
   logic [7:0] mode_r;
   logic       pin_r;

   assign wr      = psel && penable && pwrite;
   assign stat_wr = wr && paddr == {2'h0, `T1P_IDX_STAT, 2'h0};
   // No tick and no pin edge: only software can move the flag
   assign quiet   = !fcpu_tick && !fhosc_tick && capture_input_pin == pin_r;

   default clocking @(posedge core_clk); endclocking
   default disable iff (!nrst);

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         mode_r <= `T1P_MODE_RST;
         pin_r  <= 1'b0;
      end else begin
         pin_r <= capture_input_pin;
         if (wr && paddr == {2'h0, `T1P_IDX_MODE, 2'h0})
            mode_r <= {pwdata[7:3], 3'h0};
      end
   end

   AST_VEC_ADDR:
      assert property (vector_request.addr == `T1P_VECTOR)
      else $error("vector address is not the service entry");
   AST_WAKE:
      assert property (wake_request == (vector_request.req &&
                       power_mode != t1p_pkg::PM_GREEN))
      else $error("wake request does not follow request and mode");
   AST_FLAG_HOLD:
      assert property (vector_request.req && !stat_wr |=> vector_request.req)
      else $error("request dropped without software clear");
   AST_REQ_CAUSE:
      assert property ($rose(vector_request.req) |-> $past(!quiet || wr))
      else $error("request rose with no tick, edge or write");
   AST_HALT:
      assert property (!mode_r[7] && !wr |=> !$rose(vector_request.req))
      else $error("request rose while timer disabled");
   AST_MODE_RD:
      assert property (psel && penable && !pwrite &&
                       paddr == {2'h0, `T1P_IDX_MODE, 2'h0}
                       |-> prdata == {24'h0, mode_r})
      else $error("mode read differs from last write");
   AST_IEN_OFF:
      assert property (stat_wr && !pwdata[1] |=> !vector_request.req)
      else $error("request present with interrupt disabled");
   AST_SW_CLR:
      assert property (stat_wr && !pwdata[0] && quiet
                       |=> !vector_request.req)
      else $error("software clear did not remove request");
   AST_SW_SET:
      assert property (stat_wr && pwdata[1:0] == 2'h3 |=> vector_request.req)
      else $error("flag with interrupt enable gave no request");
endmodule

bind t1p_timer t1p_timer_sva u_sva (
   .core_clk(core_clk), .nrst(nrst), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .fcpu_tick(fcpu_tick),
   .fhosc_tick(fhosc_tick), .power_mode(power_mode),
   .capture_input_pin(capture_input_pin),
   .vector_request(vector_request), .wake_request(wake_request));

// ==== testbench/t1p_timer_tb_top.sv ====
// Self-checking testbench of the prescaled timer
`include "t1p_defs.svh"

module t1p_timer_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [11:0] AM = {2'h0, `T1P_IDX_MODE, 2'h0};
   localparam logic [11:0] AL = {2'h0, `T1P_IDX_CNT_LO, 2'h0};
   localparam logic [11:0] AH = {2'h0, `T1P_IDX_CNT_HI, 2'h0};
   localparam logic [11:0] AC = {2'h0, `T1P_IDX_CPT, 2'h0};
   localparam logic [11:0] AS = {2'h0, `T1P_IDX_STAT, 2'h0};
   localparam logic [11:0] AEL = {2'h0, `T1P_IDX_EVT_LO, 2'h0};
   localparam logic [11:0] AEH = {2'h0, `T1P_IDX_EVT_HI, 2'h0};
   logic              core_clk;
   logic              nrst;
   logic              psel;
   logic              penable;
   logic              pwrite;
   logic [11:0]       paddr;
   logic [31:0]       pwdata;
   logic [31:0]       prdata;
   logic              pready;
   logic              pslverr;
   logic              fcpu_tick;
   logic              fhosc_tick;
   t1p_pkg::t1p_pwr_t power_mode;
   logic              pin;
   t1p_pkg::t1p_vec_t vector_request;
   logic              wake_request;
   logic [31:0]       rdat;
   logic              perr;
   int                errors;
   int                comparisons;
   int                cyc;

   t1p_timer uut (
      .core_clk(core_clk), .nrst(nrst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .fcpu_tick(fcpu_tick),
      .fhosc_tick(fhosc_tick), .power_mode(power_mode),
      .capture_input_pin(pin), .vector_request(vector_request),
      .wake_request(wake_request));

   always #12.5ns core_clk = !core_clk;

   task automatic end_sim();
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // A hung handshake ends here rather than stalling the run
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 12000) begin
         errors++;
         $display("MISMATCH at %0t: run timed out", $time);
         end_sim();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         errors++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [7:0] d);
      @(posedge core_clk);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= {24'h0, d};
      @(posedge core_clk);
      penable <= 1'b1;
      @(posedge core_clk);
      while (pready !== 1'b1)
         @(posedge core_clk);
      rdat = prdata;
      perr = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic tick(input logic src, input int n);
      repeat (n) begin
         @(posedge core_clk);
         fcpu_tick  <= !src;
         fhosc_tick <= src;
         @(posedge core_clk);
         fcpu_tick  <= 1'b0;
         fhosc_tick <= 1'b0;
      end
   endtask

   // Outputs are looked at mid-cycle, once the edge's updates have landed
   task automatic ochk(input logic [31:0] exp);
      @(negedge core_clk);
      chk({14'h0, wake_request, vector_request}, exp);
   endtask

   task automatic t_regs();
      for (int k = 0; k < 8; k++) begin
         apb(1'b0, 12'h300 + 12'(4 * k), 8'h00);
         chk(rdat, 32'h0);
         chk({31'h0, perr}, {31'h0, k == 7});
      end
      $display("registers done");
   endtask

   task automatic t_rate();
      int d;
      for (int i = 0; i < 16; i++) begin
         d = 128 >> (i % 8);
         power_mode <= t1p_pkg::t1p_pwr_t'(i % 3);
         apb(1'b1, AH, 8'h00);
         apb(1'b1, AL, 8'h00);
         apb(1'b1, AM, {1'b0, 3'(i), 1'(i / 8), 3'h0});
         apb(1'b1, AM, {1'b1, 3'(i), 1'(i / 8), 3'h0});
         tick(i >= 8, 2 * d);
         tick(i < 8, d);
         apb(1'b1, AM, 8'h00);
         tick(i >= 8, d);
         apb(1'b0, AL, 8'h00);
         chk(rdat, 32'h2);
         apb(1'b0, AH, 8'h00);
         chk(rdat, 32'h0);
      end
      $display("rates done");
   endtask

   task automatic t_ovf();
      power_mode <= t1p_pkg::PM_NORMAL;
      apb(1'b1, AS, 8'h02);
      apb(1'b1, AH, 8'hff);
      apb(1'b1, AL, 8'h00);
      apb(1'b1, AM, 8'h70);
      apb(1'b1, AM, 8'hf0);
      tick(1'b0, 255);
      ochk(32'h0000f);
      tick(1'b0, 1);
      ochk(32'h3000f);
      apb(1'b0, AL, 8'h00);
      chk(rdat, 32'h0);
      power_mode <= t1p_pkg::PM_GREEN;
      tick(1'b0, 4);
      ochk(32'h1000f);
      apb(1'b0, AL, 8'h00);
      chk(rdat, 32'h4);
      apb(1'b0, AS, 8'h00);
      chk(rdat, 32'h3);
      apb(1'b1, AS, 8'h02);
      ochk(32'h0000f);
      apb(1'b1, AM, 8'h70);
      apb(1'b1, AH, 8'h12);
      apb(1'b0, AL, 8'h00);
      chk(rdat, 32'h4);
      apb(1'b1, AL, 8'hff);
      apb(1'b1, AM, 8'hf0);
      apb(1'b0, AL, 8'h00);
      chk(rdat, 32'hff);
      tick(1'b0, 1);
      apb(1'b0, AH, 8'h00);
      chk(rdat, 32'h12);
      $display("overflow done");
   endtask

   task automatic t_cpt();
      logic p;
      power_mode <= t1p_pkg::PM_SLOW;
      for (int s = 1; s < 4; s++) begin
         p = (s == 2);
         pin <= p;
         apb(1'b1, AH, 8'h00);
         apb(1'b1, AL, 8'h00);
         apb(1'b1, AC, 8'h84 | 8'(s));
         tick(1'b0, 2);
         pin <= !p;
         tick(1'b0, 3);
         pin <= p;
         if (s == 3) begin
            tick(1'b0, 2);
            pin <= !p;
         end
         tick(1'b0, 2);
         ochk(32'h3000f);
         apb(1'b0, AC, 8'h00);
         chk(rdat, 32'h80 | 32'(s));
         apb(1'b0, AL, 8'h00);
         chk(rdat, (s == 3) ? 32'h5 : 32'h3);
         apb(1'b1, AS, 8'h02);
      end
      apb(1'b1, AH, 8'hff);
      apb(1'b1, AL, 8'hfe);
      pin <= 1'b0;
      apb(1'b1, AC, 8'h8c);
      tick(1'b0, 2);
      pin <= 1'b1;
      tick(1'b0, 3);
      ochk(32'h3000f);
      apb(1'b0, AC, 8'h00);
      chk(rdat, 32'h88);
      apb(1'b0, AL, 8'h00);
      chk(rdat, 32'h0);
      $display("capture done");
   endtask

   // Status set and enable paths, refused access, event-counted duration
   task automatic t_evt();
      apb(1'b1, AS, 8'h00);
      ochk(32'h0000f);
      apb(1'b1, AS, 8'h03);
      ochk(32'h3000f);
      apb(1'b1, AS, 8'h01);
      ochk(32'h0000f);
      apb(1'b0, AS, 8'h00);
      chk(rdat, 32'h1);
      apb(1'b1, AM + 12'h001, 8'h00);
      chk({31'h0, perr}, 32'h1);
      apb(1'b0, AM, 8'h00);
      chk(rdat, 32'hf0);
      power_mode <= t1p_pkg::PM_GREEN;
      pin <= 1'b0;
      apb(1'b1, AS, 8'h02);
      apb(1'b1, AEH, 8'hff);
      apb(1'b1, AEL, 8'hfe);
      apb(1'b1, AH, 8'h00);
      apb(1'b1, AL, 8'h00);
      apb(1'b1, AC, 8'h84);
      tick(1'b0, 2);
      pin <= 1'b1;
      tick(1'b0, 2);
      pin <= 1'b0;
      tick(1'b0, 1);
      pin <= 1'b1;
      tick(1'b0, 1);
      apb(1'b0, AEL, 8'h00);
      chk(rdat, 32'hff);
      apb(1'b0, AEH, 8'h00);
      chk(rdat, 32'hff);
      pin <= 1'b0;
      tick(1'b0, 1);
      pin <= 1'b1;
      tick(1'b0, 1);
      ochk(32'h1000f);
      apb(1'b0, AC, 8'h00);
      chk(rdat, 32'h80);
      apb(1'b0, AL, 8'h00);
      chk(rdat, 32'h5);
      apb(1'b0, AEL, 8'h00);
      chk(rdat, 32'h0);
      $display("events done");
   endtask

   initial begin
      core_clk   = 1'b0;
      nrst       = 1'b0;
      psel       = 1'b0;
      penable    = 1'b0;
      pwrite     = 1'b0;
      paddr      = 12'h000;
      pwdata     = 32'h0;
      fcpu_tick  = 1'b0;
      fhosc_tick = 1'b0;
      power_mode = t1p_pkg::PM_NORMAL;
      pin        = 1'b0;
      repeat (12) @(posedge core_clk);
      nrst <= 1'b1;
      t_regs();
      t_rate();
      t_ovf();
      t_cpt();
      t_evt();
      end_sim();
   end
endmodule
